// *** shared/alarm_monitor_regs.svh ***
`ifndef ALARM_MONITOR_REGS_SVH
`define ALARM_MONITOR_REGS_SVH

// word addresses on the plain register port
`define VENDOR_ALARM_ENABLE_ADDR 16'hb02d
`define ENABLE_RESERVED_WORD_ADDR 16'hb02e
`define TEMPERATURE_MONITOR_ADDR 16'hb02f
`define SUPPLY_VOLTAGE_MONITOR_ADDR 16'hb030
`define AMPLIFIER_BIAS_MONITOR_ADDR 16'hb031
`define EVENT_STATUS_ADDR 16'hb0f0
`define EVENT_MASK_ADDR 16'hb0f1
`define ALARM_LATCH_ADDR 16'hb0f2

`define VENDOR_ALARM_ENABLE_RESET 16'h0000
`define MONITOR_RESET 16'h0000
`define EVENT_MASK_RESET 16'h0000

`define SUPPLY_RANGE_BIT 0
`define HW_SW_INCOMPAT_BIT 1
// bits 1..0 of the vendor enable are defined, 15..2 reserved
`define VENDOR_ENABLE_USED 16'h0003

`define EV_TEMP_BIT 0
`define EV_SUPPLY_BIT 1
`define EV_BIAS_BIT 2
`define EV_ALARM_BIT 3

`endif

// *** shared/alarm_monitor_pkg.sv ***
`default_nettype none

package alarm_monitor_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic temp_valid;
        logic [15:0] temp;
        logic supply_valid;
        logic [15:0] supply;
        logic bias_valid;
        logic [15:0] bias;
    } monitor_in_s;

endpackage : alarm_monitor_pkg

`default_nettype wire

// *** logic/alarm_monitor_regs_block.sv ***
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_monitor_regs.svh"

module alarm_monitor_regs_block
    import alarm_monitor_pkg::*;
#(
    parameter int SUPPLY_ALARMS = 4,
    parameter logic [15:0] IMPLEMENTED_ENABLES = 16'h0003
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire reg_req_s req,
    output logic [15:0] rdata,
    input wire monitor_in_s mon,
    input wire logic [SUPPLY_ALARMS-1:0] supply_alarm_status,
    input wire logic hw_sw_incompat,
    output logic global_alarm_out,
    output logic irq
);

    // one OR term per supply; a wider status set would not fit one word
    if (SUPPLY_ALARMS < 1 || SUPPLY_ALARMS > 16) begin : gen_bad_supply_alarms
        $error("SUPPLY_ALARMS must be 1 to 16");
    end

    // bits outside this mask read back zero whatever the host writes
    localparam logic [15:0] ENABLE_WRITABLE = IMPLEMENTED_ENABLES & `VENDOR_ENABLE_USED;

    logic [15:0] vendor_alarm_enable;
    logic signed [15:0] temperature_monitor;
    logic [15:0] supply_voltage_monitor;
    logic [15:0] amplifier_bias_monitor;
    logic [15:0] alarm_latch;
    logic [15:0] event_status;
    logic [15:0] event_mask;
    logic [15:0] raw_alarm;
    logic [15:0] new_event;
    logic status_read;
    logic latch_read;

    always_comb begin
        raw_alarm = 16'h0000;
        raw_alarm[`SUPPLY_RANGE_BIT] = |supply_alarm_status;
        raw_alarm[`HW_SW_INCOMPAT_BIT] = hw_sw_incompat;
    end

    assign status_read = req.rd && req.addr == `EVENT_STATUS_ADDR;
    assign latch_read = req.rd && req.addr == `ALARM_LATCH_ADDR;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            vendor_alarm_enable <= `VENDOR_ALARM_ENABLE_RESET;
        end else if (req.wr && req.addr == `VENDOR_ALARM_ENABLE_ADDR) begin
            vendor_alarm_enable <= req.wdata & ENABLE_WRITABLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            event_mask <= `EVENT_MASK_RESET;
        end else if (req.wr && req.addr == `EVENT_MASK_ADDR) begin
            event_mask <= req.wdata;
        end
    end

    // whole-word capture from a valid strobe keeps host reads coherent
    always_ff @(posedge core_clk) begin
        if (rst) begin
            temperature_monitor <= `MONITOR_RESET;
            supply_voltage_monitor <= `MONITOR_RESET;
            amplifier_bias_monitor <= `MONITOR_RESET;
        end else begin
            if (mon.temp_valid) begin
                temperature_monitor <= mon.temp;
            end
            if (mon.supply_valid) begin
                supply_voltage_monitor <= mon.supply;
            end
            if (mon.bias_valid) begin
                amplifier_bias_monitor <= mon.bias;
            end
        end
    end

    // latched alarms clear on read; a fresh alarm in the same cycle wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            alarm_latch <= 16'h0000;
        end else if (latch_read) begin
            alarm_latch <= raw_alarm;
        end else begin
            alarm_latch <= alarm_latch | raw_alarm;
        end
    end

    always_comb begin
        new_event = 16'h0000;
        new_event[`EV_TEMP_BIT] = mon.temp_valid;
        new_event[`EV_SUPPLY_BIT] = mon.supply_valid;
        new_event[`EV_BIAS_BIT] = mon.bias_valid;
        new_event[`EV_ALARM_BIT] = |(raw_alarm & ~alarm_latch);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            event_status <= 16'h0000;
        end else if (status_read) begin
            event_status <= new_event;
        end else begin
            event_status <= event_status | new_event;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            global_alarm_out <= 1'h0;
        end else begin
            global_alarm_out <= |(vendor_alarm_enable & alarm_latch);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq <= 1'h0;
        end else begin
            irq <= |(event_status & event_mask);
        end
    end

    // reads of reserved or unmapped words return zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (!req.rd) begin
            rdata <= 16'h0000;
        end else if (req.addr == `VENDOR_ALARM_ENABLE_ADDR) begin
            rdata <= vendor_alarm_enable;
        end else if (req.addr == `TEMPERATURE_MONITOR_ADDR) begin
            rdata <= temperature_monitor;
        end else if (req.addr == `SUPPLY_VOLTAGE_MONITOR_ADDR) begin
            rdata <= supply_voltage_monitor;
        end else if (req.addr == `AMPLIFIER_BIAS_MONITOR_ADDR) begin
            rdata <= amplifier_bias_monitor;
        end else if (req.addr == `EVENT_STATUS_ADDR) begin
            rdata <= event_status;
        end else if (req.addr == `EVENT_MASK_ADDR) begin
            rdata <= event_mask;
        end else if (req.addr == `ALARM_LATCH_ADDR) begin
            rdata <= alarm_latch;
        end else begin
            rdata <= 16'h0000;
        end
    end

    enable_unimpl_zero_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (vendor_alarm_enable & ~ENABLE_WRITABLE) == 16'h0000)
        else $error("unimplemented enable bit set");

    global_alarm_and_a: assert property (
        @(posedge core_clk) disable iff (rst)
        |(vendor_alarm_enable & alarm_latch) |=> global_alarm_out)
        else $error("enabled latched alarm did not raise global alarm");

    global_alarm_quiet_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (vendor_alarm_enable & alarm_latch) == 16'h0000 |=> !global_alarm_out)
        else $error("global alarm without enabled latched alarm");

    supply_or_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (|supply_alarm_status) |=> alarm_latch[`SUPPLY_RANGE_BIT])
        else $error("supply status not latched");

    temp_capture_a: assert property (
        @(posedge core_clk) disable iff (rst)
        mon.temp_valid |=> temperature_monitor == $past(mon.temp))
        else $error("temperature word not captured");

    temp_hold_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !mon.temp_valid |=> $stable(temperature_monitor))
        else $error("temperature word changed without update");

    supply_capture_a: assert property (
        @(posedge core_clk) disable iff (rst)
        mon.supply_valid |=> supply_voltage_monitor == $past(mon.supply))
        else $error("supply word not captured");

    bias_capture_a: assert property (
        @(posedge core_clk) disable iff (rst)
        mon.bias_valid |=> amplifier_bias_monitor == $past(mon.bias))
        else $error("bias word not captured");

    monitor_ro_a: assert property (
        @(posedge core_clk) disable iff (rst)
        req.wr && req.addr == `TEMPERATURE_MONITOR_ADDR && !mon.temp_valid |=> $stable(temperature_monitor))
        else $error("host write altered temperature word");

    supply_ro_a: assert property (
        @(posedge core_clk) disable iff (rst)
        req.wr && !mon.supply_valid |=> $stable(supply_voltage_monitor))
        else $error("host write altered supply word");

    supply_hold_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !mon.supply_valid |=> $stable(supply_voltage_monitor))
        else $error("supply word changed without update");

    bias_hold_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !mon.bias_valid |=> $stable(amplifier_bias_monitor))
        else $error("bias word changed without update");

    bias_ro_a: assert property (
        @(posedge core_clk) disable iff (rst)
        req.wr && !mon.bias_valid |=> $stable(amplifier_bias_monitor))
        else $error("host write altered bias word");

    enable_write_a: assert property (
        @(posedge core_clk) disable iff (rst)
        req.wr && req.addr == `VENDOR_ALARM_ENABLE_ADDR
        |=> vendor_alarm_enable == ($past(req.wdata) & ENABLE_WRITABLE))
        else $error("enable word not written as masked");

    read_enable_a: assert property (
        @(posedge core_clk) disable iff (rst)
        req.rd && req.addr == `VENDOR_ALARM_ENABLE_ADDR |=> rdata == $past(vendor_alarm_enable))
        else $error("enable word read back wrong");

    read_idle_zero_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !req.rd |=> rdata == 16'h0000)
        else $error("read data outside its cycle");

    read_temp_a: assert property (
        @(posedge core_clk) disable iff (rst)
        req.rd && req.addr == `TEMPERATURE_MONITOR_ADDR |=> rdata == $past(temperature_monitor))
        else $error("temperature word read back wrong");

    read_supply_a: assert property (
        @(posedge core_clk) disable iff (rst)
        req.rd && req.addr == `SUPPLY_VOLTAGE_MONITOR_ADDR |=> rdata == $past(supply_voltage_monitor))
        else $error("supply word read back wrong");

    read_bias_a: assert property (
        @(posedge core_clk) disable iff (rst)
        req.rd && req.addr == `AMPLIFIER_BIAS_MONITOR_ADDR |=> rdata == $past(amplifier_bias_monitor))
        else $error("bias word read back wrong");

    read_reserved_a: assert property (
        @(posedge core_clk) disable iff (rst)
        req.rd && req.addr == `ENABLE_RESERVED_WORD_ADDR |=> rdata == 16'h0000)
        else $error("reserved word read nonzero");

    hw_latch_a: assert property (
        @(posedge core_clk) disable iff (rst)
        hw_sw_incompat |=> alarm_latch[`HW_SW_INCOMPAT_BIT])
        else $error("incompatibility alarm not latched");

    latch_sticky_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !latch_read |=> (alarm_latch & $past(alarm_latch)) == $past(alarm_latch))
        else $error("latched alarm lost without a read");

    status_sticky_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !status_read |=> (event_status & $past(event_status)) == $past(event_status))
        else $error("status bit lost without a read");

    temp_event_a: assert property (
        @(posedge core_clk) disable iff (rst)
        mon.temp_valid |=> event_status[`EV_TEMP_BIT])
        else $error("temperature update not flagged");

    supply_event_a: assert property (
        @(posedge core_clk) disable iff (rst)
        mon.supply_valid |=> event_status[`EV_SUPPLY_BIT])
        else $error("supply update not flagged");

    bias_event_a: assert property (
        @(posedge core_clk) disable iff (rst)
        mon.bias_valid |=> event_status[`EV_BIAS_BIT])
        else $error("bias update not flagged");

    alarm_event_a: assert property (
        @(posedge core_clk) disable iff (rst)
        |(raw_alarm & ~alarm_latch) |=> event_status[`EV_ALARM_BIT])
        else $error("new alarm not flagged");

    irq_level_a: assert property (
        @(posedge core_clk) disable iff (rst)
        |(event_status & event_mask) |=> irq)
        else $error("unmasked status did not raise irq");

    irq_quiet_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (event_status & event_mask) == 16'h0000 |=> !irq)
        else $error("irq without unmasked status");

endmodule : alarm_monitor_regs_block

`default_nettype wire

// *** tb/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module host_model
    import alarm_monitor_pkg::*;
(
    input wire logic core_clk,
    output var reg_req_s req,
    input wire logic [15:0] rdata
);
    initial req = '0;

    // an idle edge after each strobe keeps two drives of req out of one time step
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge core_clk);
        req <= '0;
        @(posedge core_clk);
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'h0, rd: 1'h1};
        @(posedge core_clk);
        req <= '0;
        #1 d = rdata;
        @(posedge core_clk);
    endtask : rd
endmodule : host_model

`default_nettype wire

// *** tb/module_alarm_enable_and_monitor_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "alarm_monitor_regs.svh"

module module_alarm_enable_and_monitor_regs_tb
    import alarm_monitor_pkg::*;
;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    reg_req_s req;
    logic [15:0] rdata;
    monitor_in_s mon;
    logic [3:0] sup;
    logic hw;
    logic glb;
    logic irq;
    int mismatches = 0;
    int num_checks = 0;

    always #5 core_clk = ~core_clk;

    alarm_monitor_regs_block alarm_monitor_regs_block_inst (
        .core_clk(core_clk),
        .rst(rst),
        .req(req),
        .rdata(rdata),
        .mon(mon),
        .supply_alarm_status(sup),
        .hw_sw_incompat(hw),
        .global_alarm_out(glb),
        .irq(irq)
    );

    host_model host_model_inst (
        .core_clk(core_clk),
        .req(req),
        .rdata(rdata)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host_model_inst.rd(a, d);
        check(d, exp);
    endtask : rdc

    task automatic results();
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    // writes to read-only and reserved words must leave the reset zeros
    task automatic t_readonly();
        rdc(`VENDOR_ALARM_ENABLE_ADDR, 16'h0000);
        host_model_inst.wr(`TEMPERATURE_MONITOR_ADDR, 16'hffff);
        host_model_inst.wr(`SUPPLY_VOLTAGE_MONITOR_ADDR, 16'hffff);
        host_model_inst.wr(`AMPLIFIER_BIAS_MONITOR_ADDR, 16'hffff);
        host_model_inst.wr(`ENABLE_RESERVED_WORD_ADDR, 16'hffff);
        rdc(`TEMPERATURE_MONITOR_ADDR, 16'h0000);
        rdc(`SUPPLY_VOLTAGE_MONITOR_ADDR, 16'h0000);
        rdc(`AMPLIFIER_BIAS_MONITOR_ADDR, 16'h0000);
        rdc(`ENABLE_RESERVED_WORD_ADDR, 16'h0000);
        rdc(16'h0123, 16'h0000);
    endtask : t_readonly

    // data changes right after the pulse, so only the pulsed word may be kept
    task automatic t_monitor();
        host_model_inst.wr(`EVENT_MASK_ADDR, 16'h0007);
        rdc(`EVENT_MASK_ADDR, 16'h0007);
        mon <= '{1'h1, 16'h8000, 1'h1, 16'hffff, 1'h1, 16'h1234};
        @(posedge core_clk);
        mon <= '{1'h0, 16'h00ff, 1'h0, 16'h0001, 1'h0, 16'hedcb};
        @(posedge core_clk);
        @(negedge core_clk);
        check(irq, 16'h0001);
        @(posedge core_clk);
        rdc(`TEMPERATURE_MONITOR_ADDR, 16'h8000);
        rdc(`SUPPLY_VOLTAGE_MONITOR_ADDR, 16'hffff);
        rdc(`AMPLIFIER_BIAS_MONITOR_ADDR, 16'h1234);
        rdc(`EVENT_STATUS_ADDR, 16'h0007);
        rdc(`EVENT_STATUS_ADDR, 16'h0000);
        @(negedge core_clk);
        check(irq, 16'h0000);
        @(posedge core_clk);
    endtask : t_monitor

    // a read clears the latch, but a live alarm sets it again at once
    task automatic t_alarm();
        host_model_inst.wr(`VENDOR_ALARM_ENABLE_ADDR, 16'hffff);
        rdc(`VENDOR_ALARM_ENABLE_ADDR, 16'h0003);
        sup <= 4'h4;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        check(glb, 16'h0001);
        @(posedge core_clk);
        sup <= 4'h0;
        rdc(`ALARM_LATCH_ADDR, 16'h0001);
        @(negedge core_clk);
        check(glb, 16'h0000);
        @(posedge core_clk);
        hw <= 1'h1;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        check(glb, 16'h0001);
        @(posedge core_clk);
        host_model_inst.wr(`VENDOR_ALARM_ENABLE_ADDR, 16'h0001);
        @(negedge core_clk);
        check(glb, 16'h0000);
        @(posedge core_clk);
        rdc(`ALARM_LATCH_ADDR, 16'h0002);
        rdc(`ALARM_LATCH_ADDR, 16'h0002);
        host_model_inst.wr(`EVENT_MASK_ADDR, 16'h0008);
        @(negedge core_clk);
        check(irq, 16'h0001);
        @(posedge core_clk);
        rdc(`EVENT_STATUS_ADDR, 16'h0008);
    endtask : t_alarm

    // a reset in mid-run brings the monitor, enable, mask and latch words back to their reset values
    task automatic t_reset();
        hw <= 1'h0;
        rst <= 1'h1;
        repeat (2) @(posedge core_clk);
        rst <= 1'h0;
        @(posedge core_clk);
        rdc(`TEMPERATURE_MONITOR_ADDR, 16'h0000);
        rdc(`SUPPLY_VOLTAGE_MONITOR_ADDR, 16'h0000);
        rdc(`AMPLIFIER_BIAS_MONITOR_ADDR, 16'h0000);
        rdc(`VENDOR_ALARM_ENABLE_ADDR, 16'h0000);
        rdc(`EVENT_MASK_ADDR, 16'h0000);
        rdc(`ALARM_LATCH_ADDR, 16'h0000);
    endtask : t_reset

    initial begin
        mon = '0;
        sup = 4'h0;
        hw = 1'h0;
        repeat (10) @(posedge core_clk);
        rst <= 1'h0;
        @(posedge core_clk);
        t_readonly();
        t_monitor();
        t_alarm();
        t_reset();
        results();
    end

    initial begin
        #100000;
        mismatches++;
        results();
    end
endmodule : module_alarm_enable_and_monitor_regs_tb

`default_nettype wire
